// File: hdl/uart_host_port_flow_ctrl.v
// Purpose: Host-facing UART with rx/tx buffers, CTS/RTS flow control, packetizer triggers
// Assumes: One clock, sync active-high reset, host line synchronised inside
// Notes:   Radio side sees byte streams plus packet and drop pulses
// Functional notes
// - Frame: low start, eight data bits LSB first, high stop.
// - Both ends share baud and parity; device times bits and checks parity.
// - Every received character enters the receive buffer until radio consumes it; bytes with a low stop bit or arriving at a full buffer are discarded.
// - No draining toward radio while radio data keeps arriving.
// - Radio payload goes to transmit buffer then out on serial output.
// - Radio packet not fitting transmit buffer free space is dropped whole.
// - RTS and CTS throttling each have their own enable.
// - CTS goes high once receive occupancy reaches flow_threshold.
// - CTS returns low only below flow_threshold minus 16, or when CTS throttling is disabled.
// - With RTS enabled, no transmit byte starts while RTS is high.
// - Transparent mode queues all serial bytes, forwards radio payload unchanged.
// - Packetize after serial input silent for packetization_timeout.
// - Timeout zero packetizes as soon as a character arrives.
// - Command sequence packetizes everything buffered before it first.
// - Packetize when buffered count reaches the maximum payload.
`include "uart_host_port_regs.vh"

module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             sys_rst,
    // Fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // Drain side
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    // Occupancy
    output wire [AW:0]      count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    wire            push = in_valid && in_ready;
    wire            pop  = out_valid && out_ready;
    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem[rp_r];
    assign count     = cnt_r;
    always @(posedge clk) begin
        if (push)
            mem[wp_r] <= in_data;
    end
    always @(posedge clk) begin
        if (sys_rst) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule

module uart_host_port_flow_ctrl #(
    parameter BIT_CYCLES  = `BIT_CYCLES,
    parameter DEPTH       = `FIFO_DEPTH,
    parameter AW          = 3,
    parameter MAX_PAYLOAD = `MAX_PAYLOAD
) (
    input  wire         clk,
    input  wire         sys_rst,
    // Host pins
    input  wire         serial_in,
    output reg          serial_out,
    input  wire         rts_n,
    output reg          cts_n,
    // Configuration
    input  wire         rts_enable_cmd,
    input  wire         cts_enable_cmd,
    input  wire [1:0]   parity_mode,
    input  wire [AW:0]  flow_threshold,
    input  wire [15:0]  packetization_timeout,
    input  wire         transparent_mode,
    input  wire         command_seq_seen,
    // Radio side, serial-to-radio stream
    output wire [7:0]   radio_tx_data,
    output wire         radio_tx_valid,
    input  wire         radio_tx_ready,
    input  wire         radio_rx_busy,
    output reg          packetize,
    // Radio side, radio-to-serial stream
    input  wire [7:0]   radio_rx_data,
    input  wire         radio_rx_valid,
    output wire         radio_rx_ready,
    input  wire         pkt_start,
    input  wire [AW:0]  pkt_len,
    output reg          pkt_dropped,
    // Status
    output reg          framing_error,
    output reg          parity_error,
    output reg          overflow,
    output wire [AW:0]  rx_level
);
    localparam [15:0] BITC = BIT_CYCLES[15:0];
    localparam [15:0] HALF = BITC / 16'h0002;
    localparam [1:0] S_IDLE = 2'h0, S_DATA = 2'h1, S_PAR = 2'h2, S_STOP = 2'h3;

    // Two-flop synchronisers for pins
    reg  [1:0] rxd_sync_r;
    reg  [1:0] rts_sync_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            rxd_sync_r <= 2'h3;
            rts_sync_r <= 2'h3;
        end else begin
            rxd_sync_r <= {rxd_sync_r[0], serial_in};
            rts_sync_r <= {rts_sync_r[0], rts_n};
        end
    end
    wire rxd = rxd_sync_r[1];
    wire rts_high = rts_sync_r[1];

    // Receiver
    reg [1:0]  rs_r;
    reg [15:0] rc_r;
    reg [2:0]  rb_r;
    reg [7:0]  rsh_r;
    reg        rpar_r;
    reg        rx_push;
    reg [7:0]  rx_byte;
    wire       rx_in_ready;
    wire       par_on = (parity_mode != `PARITY_NONE);
    wire       par_exp = ^rsh_r ^ (parity_mode == `PARITY_ODD);
    always @(posedge clk) begin
        if (sys_rst) begin
            rs_r <= S_IDLE;
            rc_r <= 16'h0000;
            rb_r <= 3'h0;
            rsh_r <= 8'h00;
            rpar_r <= 1'b0;
            rx_push <= 1'b0;
            rx_byte <= 8'h00;
            framing_error <= 1'b0;
            parity_error <= 1'b0;
            overflow <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            framing_error <= 1'b0;
            parity_error <= 1'b0;
            overflow <= 1'b0;
            case (rs_r)
                S_IDLE: begin
                    if (!rxd) begin
                        if (rc_r == HALF) begin
                            rs_r <= S_DATA;
                            rc_r <= 16'h0000;
                            rb_r <= 3'h0;
                        end else
                            rc_r <= rc_r + 16'h0001;
                    end else
                        rc_r <= 16'h0000;
                end
                S_DATA: begin
                    if (rc_r == BITC - 16'h0001) begin
                        rc_r <= 16'h0000;
                        rsh_r <= {rxd, rsh_r[7:1]};
                        rb_r <= rb_r + 3'h1;
                        if (rb_r == 3'h7)
                            rs_r <= par_on ? S_PAR : S_STOP;
                    end else
                        rc_r <= rc_r + 16'h0001;
                end
                S_PAR: begin
                    if (rc_r == BITC - 16'h0001) begin
                        rc_r <= 16'h0000;
                        rpar_r <= rxd;
                        rs_r <= S_STOP;
                    end else
                        rc_r <= rc_r + 16'h0001;
                end
                S_STOP: begin
                    if (rc_r == BITC - 16'h0001) begin
                        rc_r <= 16'h0000;
                        rs_r <= S_IDLE;
                        if (!rxd)
                            framing_error <= 1'b1;
                        else begin
                            if (par_on && rpar_r != par_exp)
                                parity_error <= 1'b1;
                            if (rx_in_ready) begin
                                rx_push <= 1'b1;
                                rx_byte <= rsh_r;
                            end else
                                overflow <= 1'b1;
                        end
                    end else
                        rc_r <= rc_r + 16'h0001;
                end
                default: rs_r <= S_IDLE;
            endcase
        end
    end

    // Receive buffer; held while radio reception is busy
    wire radio_tx_valid_i;
    wire rx_drain_ready = radio_tx_ready && !radio_rx_busy;
    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) rx_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   (rx_byte),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .out_data  (radio_tx_data),
        .out_valid (radio_tx_valid_i),
        .out_ready (rx_drain_ready),
        .count     (rx_level)
    );
    assign radio_tx_valid = radio_tx_valid_i && !radio_rx_busy;

    // CTS with hysteresis; active low pin
    always @(posedge clk) begin
        if (sys_rst)
            cts_n <= 1'b0;
        else if (!cts_enable_cmd)
            cts_n <= 1'b0;
        else if (rx_level >= flow_threshold)
            cts_n <= 1'b1;
        else if ({1'b0, rx_level} + `CTS_HYSTERESIS < {1'b0, flow_threshold})
            cts_n <= 1'b0;
    end

    // Packetization triggers; silence measured in bit times
    reg [15:0] sil_c_r;
    reg [15:0] sil_b_r;
    reg        pend_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            sil_c_r <= 16'h0000;
            sil_b_r <= 16'h0000;
            pend_r <= 1'b0;
            packetize <= 1'b0;
        end else begin
            packetize <= 1'b0;
            if (rx_push) begin
                sil_c_r <= 16'h0000;
                sil_b_r <= 16'h0000;
                pend_r <= 1'b1;
            end else if (sil_c_r == BITC - 16'h0001) begin
                sil_c_r <= 16'h0000;
                if (sil_b_r != 16'hFFFF)
                    sil_b_r <= sil_b_r + 16'h0001;
            end else
                sil_c_r <= sil_c_r + 16'h0001;
            if (transparent_mode) begin
                if (command_seq_seen && rx_level != {(AW+1){1'b0}}) begin
                    packetize <= 1'b1;
                    pend_r <= 1'b0;
                end else if (rx_push && packetization_timeout == 16'h0000) begin
                    packetize <= 1'b1;
                    pend_r <= 1'b0;
                end else if (pend_r && {{(31-AW){1'b0}}, rx_level} >= MAX_PAYLOAD) begin
                    packetize <= 1'b1;
                    pend_r <= 1'b0;
                end else if (pend_r && !rx_push && sil_b_r >= packetization_timeout) begin
                    packetize <= 1'b1;
                    pend_r <= 1'b0;
                end
            end
        end
    end

    // Transmit buffer with whole-packet admission
    wire [AW:0] tx_level;
    wire [7:0]  tx_data;
    wire        tx_valid;
    reg         tx_pop;
    reg         admit_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            admit_r <= 1'b0;
            pkt_dropped <= 1'b0;
        end else begin
            pkt_dropped <= 1'b0;
            if (pkt_start) begin
                if ({1'b0, pkt_len} + {1'b0, tx_level} > DEPTH) begin
                    admit_r <= 1'b0;
                    pkt_dropped <= 1'b1;
                end else
                    admit_r <= 1'b1;
            end
        end
    end
    wire tx_in_ready;
    // Dropped bytes are swallowed so the radio never stalls on them
    assign radio_rx_ready = admit_r ? tx_in_ready : 1'b1;
    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) tx_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   (radio_rx_data),
        .in_valid  (radio_rx_valid && admit_r),
        .in_ready  (tx_in_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_pop),
        .count     (tx_level)
    );

    // Transmitter; frame: start, 8 data, optional parity, stop
    reg [3:0]  tb_r;
    reg [15:0] tc_r;
    reg [10:0] tsh_r;
    reg        tbusy_r;
    wire       can_start = tx_valid && !tbusy_r && !(rts_enable_cmd && rts_high);
    wire       tpar = ^tx_data ^ (parity_mode == `PARITY_ODD);
    always @* begin
        tx_pop = can_start;
    end
    always @(posedge clk) begin
        if (sys_rst) begin
            tbusy_r <= 1'b0;
            tb_r <= 4'h0;
            tc_r <= 16'h0000;
            tsh_r <= 11'h7FF;
            serial_out <= 1'b1;
        end else if (can_start) begin
            tbusy_r <= 1'b1;
            tc_r <= 16'h0000;
            serial_out <= 1'b0;
            tsh_r <= par_on ? {1'b1, tpar, tx_data, 1'b0} : {2'h3, tx_data, 1'b0};
            tb_r <= par_on ? 4'hA : 4'h9;
        end else if (tbusy_r) begin
            if (tc_r == BITC - 16'h0001) begin
                tc_r <= 16'h0000;
                if (tb_r == 4'h0) begin
                    tbusy_r <= 1'b0;
                    serial_out <= 1'b1;
                end else begin
                    tsh_r <= {1'b1, tsh_r[10:1]};
                    serial_out <= tsh_r[1];
                    tb_r <= tb_r - 4'h1;
                end
            end else
                tc_r <= tc_r + 16'h0001;
        end
    end
endmodule

// File: hdl/uart_host_port_regs.vh
// Purpose: Constants for the host serial port with flow control
// Assumes: 125 MHz clk, 8N1 framing by default
// Notes:   Counts are in clk cycles unless named otherwise
`ifndef UART_HOST_PORT_REGS_VH
`define UART_HOST_PORT_REGS_VH
`define CLK_HZ            125000000
`define BAUD_DEFAULT      115200
`define BIT_CYCLES        (`CLK_HZ / `BAUD_DEFAULT)
`define CTS_HYSTERESIS    16
`define FLOW_THR_DEFAULT  8'h40
`define FIFO_DEPTH        8
`define RX_FIFO_DEPTH     256
`define TX_FIFO_DEPTH     256
`define MAX_PAYLOAD       64
`define PARITY_NONE       2'h0
`define PARITY_EVEN       2'h1
`define PARITY_ODD        2'h2
`endif

// File: test/uart_port_properties.sv
// Purpose: Port assertions for the host serial port
// Assumes: Bound onto the top module, one clock domain
// Notes:   RTS window lets an 11-bit frame in flight finish
module uart_port_checker #(parameter BIT_CYCLES = 8, DEPTH = 8, AW = 3, MAX_PAYLOAD = 4) (
    // Pins and enables
    input wire logic        clk, sys_rst, serial_out, rts_n, cts_n, rts_enable_cmd, cts_enable_cmd,
    // Radio side and status
    input wire logic        transparent_mode, radio_tx_valid, radio_rx_busy, packetize,
    input wire logic        pkt_start, pkt_dropped, overflow,
    input wire logic [AW:0] flow_threshold, pkt_len, rx_level,
    input wire logic [15:0] packetization_timeout
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] hold_r;
    // Saturates so a long hold never wraps
    always @(posedge clk)
        hold_r <= (sys_rst || !(rts_enable_cmd && rts_n)) ? 8'h00 : hold_r + {7'h00, hold_r != 8'hFF};
    cts_off_a: assert property (!cts_enable_cmd |=> !cts_n)
        else $error("cts raised while disabled");
    cts_set_a: assert property (cts_enable_cmd && rx_level >= flow_threshold |=> cts_n)
        else $error("cts not raised at threshold");
    cts_hold_a: assert property (cts_n && cts_enable_cmd && int'(rx_level) + 16 >= int'(flow_threshold)
        ##1 cts_enable_cmd |-> cts_n) else $error("cts released too early");
    drain_hold_a: assert property (radio_rx_busy |-> !radio_tx_valid)
        else $error("drain while radio busy");
    ovf_full_a: assert property (overflow |-> int'($past(rx_level)) == DEPTH)
        else $error("overflow without full buffer");
    rts_hold_a: assert property (int'(hold_r) > 12 * BIT_CYCLES + 4 |-> serial_out)
        else $error("frame sent while rts high");
    pkt_drop_a: assert property (pkt_start && int'(pkt_len) > DEPTH |-> ##[1:2] pkt_dropped)
        else $error("oversize packet not dropped");
    pkt_zero_a: assert property (transparent_mode && packetization_timeout == 16'h0000
        && rx_level > $past(rx_level) |-> ##[0:3] packetize) else $error("no packetize on byte");
    pkt_max_a: assert property (transparent_mode && int'(rx_level) >= MAX_PAYLOAD && rx_level > $past(rx_level)
        |-> ##[0:3] packetize) else $error("no packetize at payload limit");
    cover property (cts_n);
    cover property (pkt_dropped);
    cover property (packetize);
endmodule

// File: test/host_uart_model.sv
// Purpose: Host side UART with RTS
// Assumes: Same bit time as the port
// Notes:   Sends whole frames given LSB first
module host_uart_model #(parameter int BIT_CYCLES = 8) (
    input  wire logic clk,
    output logic      serial_in,
    input  wire logic serial_out,
    output logic      rts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        serial_in = 1'b1;
        rts_n = 1'b0;
    end
    task automatic send_bits(input logic [10:0] frame, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            serial_in <= frame[i];
            repeat (BIT_CYCLES - 1) @(posedge clk);
        end
        @(posedge clk);
        serial_in <= 1'b1;
        repeat (BIT_CYCLES) @(posedge clk);
    endtask
    // Short holds only, a long hold fills the port's buffer
    task automatic set_rts(input logic v);
        @(posedge clk);
        rts_n <= v;
    endtask
    task automatic recv_byte(output logic [7:0] d, output logic stop);
        int i;
        d = 8'h00;
        for (i = 0; i < 40 * BIT_CYCLES && serial_out !== 1'b0; i++) @(posedge clk);
        // No start bit in time: unknown stop tells the caller
        if (serial_out !== 1'b0) begin
            stop = 1'bx;
            return;
        end
        repeat (BIT_CYCLES / 2) @(posedge clk);
        for (int b = 0; b < 8; b++) begin
            repeat (BIT_CYCLES) @(posedge clk);
            d[b] = serial_out;
        end
        repeat (BIT_CYCLES) @(posedge clk);
        stop = serial_out;
    endtask
endmodule

// File: test/testbench.sv
// Purpose: Self-checking bench for the host serial port
// Assumes: Short bit time and payload limit keep the run brief
// Notes:   Radio side is driven by the bench itself
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 8;
    logic        clk, sys_rst, serial_in, rts_n, rts_enable_cmd, cts_enable_cmd, transparent_mode, s;
    logic        command_seq_seen, radio_tx_ready, radio_rx_busy, radio_rx_valid, pkt_start, serial_out;
    logic        cts_n, radio_tx_valid, packetize, radio_rx_ready, pkt_dropped, framing_error, parity_error, overflow;
    logic [1:0]  parity_mode;
    logic [3:0]  flow_threshold, pkt_len, rx_level;
    logic [15:0] packetization_timeout;
    logic [7:0]  radio_rx_data, radio_tx_data, d;
    int          err_total, checks, n_pk, n_dr, n_fe, n_pe, n_ov, n0;
    uart_host_port_flow_ctrl #(.BIT_CYCLES(BC), .DEPTH(8), .AW(3), .MAX_PAYLOAD(4)) DUT (
        .clk(clk), .sys_rst(sys_rst), .serial_in(serial_in), .serial_out(serial_out), .rts_n(rts_n),
        .cts_n(cts_n), .rts_enable_cmd(rts_enable_cmd), .cts_enable_cmd(cts_enable_cmd),
        .parity_mode(parity_mode), .flow_threshold(flow_threshold), .packetization_timeout(packetization_timeout),
        .transparent_mode(transparent_mode), .command_seq_seen(command_seq_seen), .radio_tx_data(radio_tx_data),
        .radio_tx_valid(radio_tx_valid), .radio_tx_ready(radio_tx_ready), .radio_rx_busy(radio_rx_busy),
        .packetize(packetize), .radio_rx_data(radio_rx_data), .radio_rx_valid(radio_rx_valid),
        .radio_rx_ready(radio_rx_ready), .pkt_start(pkt_start), .pkt_len(pkt_len), .pkt_dropped(pkt_dropped),
        .framing_error(framing_error), .parity_error(parity_error), .overflow(overflow), .rx_level(rx_level));
    host_uart_model #(.BIT_CYCLES(BC)) host (.clk(clk), .serial_in(serial_in), .serial_out(serial_out), .rts_n(rts_n));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        n_pk += int'(packetize === 1'b1);
        n_dr += int'(pkt_dropped === 1'b1);
        n_fe += int'(framing_error === 1'b1);
        n_pe += int'(parity_error === 1'b1);
        n_ov += int'(overflow === 1'b1);
    end
    task chk(input logic [15:0] g, e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wl(input int v);
        int i;
        for (i = 0; i < 40 * BC && rx_level !== v[3:0]; i++) @(posedge clk);
        if (i == 40 * BC) begin
            err_total++;
            close_out;
        end
    endtask
    task sb(input logic [7:0] b);
        host.send_bits({2'b11, b, 1'b0}, 10);
    endtask
    task rb;
        host.recv_byte(d, s);
        if (s === 1'bx) begin
            err_total++;
            close_out;
        end
    endtask
    task rpkt(input logic [3:0] n, input logic [7:0] b);
        int i;
        @(posedge clk);
        pkt_start <= 1'b1;
        pkt_len <= n;
        @(posedge clk);
        pkt_start <= 1'b0;
        for (int k = 0; k < n; k++) begin
            radio_rx_data <= b + k[7:0];
            radio_rx_valid <= 1'b1;
            @(posedge clk);
            for (i = 1; i < 50 && radio_rx_ready !== 1'b1; i++) @(posedge clk);
            if (radio_rx_ready !== 1'b1) begin
                err_total++;
                close_out;
            end
        end
        radio_rx_valid <= 1'b0;
    endtask
    initial begin
        {err_total, checks, n_pk, n_dr, n_fe, n_pe, n_ov} = '0;
        {rts_enable_cmd, cts_enable_cmd, command_seq_seen, radio_tx_ready, radio_rx_valid, pkt_start} = '0;
        {parity_mode, pkt_len, radio_rx_data, packetization_timeout} = '0;
        {sys_rst, transparent_mode, radio_rx_busy} = 3'b111;
        flow_threshold = 4'h6;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        n0 = n_pk;
        sb(8'hA5);
        wl(1);
        repeat (4) @(posedge clk);
        chk(n_pk - n0, 1);
        radio_tx_ready <= 1'b1;
        repeat (20) @(posedge clk);
        chk(rx_level, 1);
        radio_rx_busy <= 1'b0;
        radio_tx_ready <= 1'b0;
        repeat (3) @(posedge clk);
        chk(radio_tx_data, 8'hA5);
        radio_tx_ready <= 1'b1;
        wl(0);
        packetization_timeout <= 16'h0002;
        n0 = n_pk;
        sb(8'h11);
        chk(n_pk - n0, 0);
        repeat (4 * BC) @(posedge clk);
        chk(n_pk - n0, 1);
        wl(0);
        radio_tx_ready <= 1'b0;
        packetization_timeout <= 16'h00FF;
        n0 = n_pk;
        for (int i = 0; i < 4; i++) sb(8'h30 + i[7:0]);
        wl(4);
        repeat (3) @(posedge clk);
        chk(n_pk - n0, 1);
        n0 = n_pk;
        command_seq_seen <= 1'b1;
        @(posedge clk);
        command_seq_seen <= 1'b0;
        repeat (4) @(posedge clk);
        chk(n_pk - n0, 1);
        cts_enable_cmd <= 1'b1;
        sb(8'h34);
        wl(5);
        chk(cts_n, 0);
        sb(8'h35);
        wl(6);
        repeat (2) @(posedge clk);
        chk(cts_n, 1);
        sb(8'h36); // host ignores the stop on purpose
        sb(8'h37);
        n0 = n_ov;
        sb(8'h38);
        chk(n_ov - n0, 1);
        chk(rx_level, 8);
        radio_tx_ready <= 1'b1;
        wl(0);
        chk(cts_n, 1);
        cts_enable_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        chk(cts_n, 0);
        radio_tx_ready <= 1'b0;
        n0 = n_fe;
        host.send_bits({2'b10, 8'h5A, 1'b0}, 10);
        chk(n_fe - n0, 1);
        chk(rx_level, 0);
        for (int m = 1; m < 3; m++) begin
            parity_mode <= m[1:0];
            n0 = n_pe;
            host.send_bits({1'b1, m == 2, 8'h3C, 1'b0}, 11);
            chk(n_pe - n0, 0);
            host.send_bits({1'b1, m == 1, 8'h3C, 1'b0}, 11);
            chk(n_pe - n0, 1);
        end
        wl(4);
        radio_tx_ready <= 1'b1;
        parity_mode <= 2'h0;
        wl(0);
        rts_enable_cmd <= 1'b1;
        host.set_rts(1'b1);
        rpkt(4'h3, 8'hC0);
        repeat (14 * BC) @(posedge clk);
        chk(serial_out, 1);
        n0 = n_dr;
        rpkt(4'h6, 8'hD0);
        chk(n_dr - n0, 1);
        rpkt(4'h9, 8'hF0);
        chk(n_dr - n0, 2);
        rts_enable_cmd <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            rb;
            chk({s, d}, {1'b1, 8'hC0 + k[7:0]});
        end
        rts_enable_cmd <= 1'b1;
        host.set_rts(1'b0);
        rpkt(4'h1, 8'hE7);
        rb;
        chk({s, d}, 9'h1E7);
        close_out;
    end
endmodule
bind uart_host_port_flow_ctrl uart_port_checker #(.BIT_CYCLES(BIT_CYCLES), .DEPTH(DEPTH), .AW(AW),
    .MAX_PAYLOAD(MAX_PAYLOAD)) u_chk (.clk(clk), .sys_rst(sys_rst), .serial_out(serial_out), .rts_n(rts_n),
    .cts_n(cts_n), .rts_enable_cmd(rts_enable_cmd), .cts_enable_cmd(cts_enable_cmd),
    .transparent_mode(transparent_mode), .radio_tx_valid(radio_tx_valid), .radio_rx_busy(radio_rx_busy),
    .packetize(packetize), .pkt_start(pkt_start), .pkt_dropped(pkt_dropped), .overflow(overflow),
    .flow_threshold(flow_threshold), .pkt_len(pkt_len), .rx_level(rx_level),
    .packetization_timeout(packetization_timeout));
